// file: hdl/ubm_pkg.sv
// break address and cycle matcher: shared constants
// assumes a 32-bit classic wishbone register bus and single-clock core buses
package ubm_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_A_ADDR = 8'h00;
    localparam logic [7:0] OFF_A_MASK = 8'h04;
    localparam logic [7:0] OFF_A_CYC  = 8'h08;
    localparam logic [7:0] OFF_B_ADDR = 8'h0C;
    localparam logic [7:0] OFF_B_MASK = 8'h10;
    localparam logic [7:0] OFF_B_CYC  = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [7:0]  CYC_RST  = 8'h00;
    localparam logic [1:0]  SEEN_RST = 2'h0;

    // ------------------------------------------------------------
    // cycle qualifier field positions (low bit of each field)
    // ------------------------------------------------------------
    localparam int BUS_POS = 6;
    localparam int ACC_POS = 4;
    localparam int DIR_POS = 2;
    localparam int SZ_POS  = 0;
    localparam int NCHAN   = 2;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] BUS_OFF   = 2'h0;
    localparam logic [1:0] BUS_LBUS  = 2'h1;
    localparam logic [1:0] BUS_IBUS  = 2'h2;
    localparam logic [1:0] ACC_FETCH = 2'h1;
    localparam logic [1:0] ACC_DATA  = 2'h2;
    localparam logic [1:0] ACC_ANY   = 2'h3;
    localparam logic [1:0] DIR_READ  = 2'h1;
    localparam logic [1:0] DIR_WRITE = 2'h2;
    localparam logic [1:0] DIR_ANY   = 2'h3;
    localparam logic [1:0] SZ_IGNORE = 2'h0;

endpackage

// file: hdl/ubm_cycle_qual.sv
// cycle qualifier: checks one bus cycle against access, direction, size fields
// assumes bus attributes are already steered from the selected bus
`timescale 1ns/1ps
module ubm_cycle_qual (
    // programmed fields, all 8 bits of a cycle qualifier; bits 5:0 are decoded
    input  wire logic [7:0] fields_i,
    // attributes of the watched cycle
    input  wire logic       fetch_i,
    input  wire logic       write_i,
    input  wire logic [1:0] size_i,
    // all enabled qualifiers hold
    output logic            qual_o
);

    logic [1:0] acc_f;
    logic [1:0] dir_f;
    logic [1:0] sz_f;
    logic       acc_ok;
    logic       dir_ok;
    logic       sz_ok;

    assign acc_f = fields_i[ubm_pkg::ACC_POS +: 2];
    assign dir_f = fields_i[ubm_pkg::DIR_POS +: 2];
    assign sz_f  = fields_i[ubm_pkg::SZ_POS +: 2];

    // field decode; a zero access or direction field leaves the channel idle
    always_comb begin
        case (acc_f)
            ubm_pkg::ACC_FETCH: acc_ok = fetch_i;
            ubm_pkg::ACC_DATA:  acc_ok = ~fetch_i;
            ubm_pkg::ACC_ANY:   acc_ok = 1'b1;
            default:            acc_ok = 1'b0;
        endcase
        case (dir_f)
            ubm_pkg::DIR_READ:  dir_ok = ~write_i;
            ubm_pkg::DIR_WRITE: dir_ok = write_i;
            ubm_pkg::DIR_ANY:   dir_ok = 1'b1;
            default:            dir_ok = 1'b0;
        endcase
        sz_ok  = (sz_f == ubm_pkg::SZ_IGNORE) || (sz_f == size_i);
        qual_o = acc_ok & dir_ok & sz_ok;
    end

endmodule

// file: hdl/ubm_addr_cmp.sv
// masked address comparator for one channel
// assumes compare and mask come from registers on the same clock
`timescale 1ns/1ps
module ubm_addr_cmp (
    // watched address
    input  wire logic [31:0] addr_i,
    // programmed compare value and mask
    input  wire logic [31:0] cmp_i,
    input  wire logic [31:0] mask_i,
    // every unmasked bit equal
    output logic             eq_o
);

    logic [31:0] miss;

    // one bit cell per address position; a set mask bit forces agreement
    for (genvar n = 0; n < 32; n++) begin : g_bit
        // per-bit mask, same cell for both channels
        assign miss[n] = (addr_i[n] ^ cmp_i[n]) & ~mask_i[n];
    end

    assign eq_o = ~|miss;

endmodule

// file: hdl/ubm_break_matcher.sv
// break address and cycle matcher: two channels, registers on wishbone
// assumes core bus attributes are on clk_i and valid for one cycle per access
`timescale 1ns/1ps
module ubm_break_matcher (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // L-bus cycle
    input  wire logic        lbus_valid_i,
    input  wire logic [31:0] lbus_address_i,
    input  wire logic        lbus_fetch_i,
    input  wire logic        lbus_write_i,
    input  wire logic [1:0]  lbus_size_i,
    // I-bus cycle
    input  wire logic        ibus_valid_i,
    input  wire logic [31:0] ibus_address_i,
    input  wire logic        ibus_fetch_i,
    input  wire logic        ibus_write_i,
    input  wire logic [1:0]  ibus_size_i,
    // per-channel match and combined break request
    output logic      [1:0]  chan_match_o,
    output logic             break_req_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0][31:0] addr_q;
    logic [1:0][31:0] addr_d;
    logic [1:0][31:0] mask_q;
    logic [1:0][31:0] mask_d;
    logic [1:0][7:0]  cyc_q;
    logic [1:0][7:0]  cyc_d;
    logic [1:0]       seen_q;
    logic [1:0]       seen_d;
    logic             ack_q;
    logic             ack_d;
    logic [31:0]      rdat_q;
    logic [31:0]      rdat_d;
    logic [1:0]       match_q;
    logic [1:0]       match_d;
    logic             brk_q;
    logic             brk_d;
    logic             take;

    // ------------------------------------------------------------
    // byte-lane merge
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // per-channel matching
    // ------------------------------------------------------------
    logic [1:0]       sel_valid;
    logic [1:0][31:0] sel_addr;
    logic [1:0]       sel_fetch;
    logic [1:0]       sel_write;
    logic [1:0][1:0]  sel_size;
    logic [1:0]       qual;
    logic [1:0]       addr_eq;

    for (genvar c = 0; c < ubm_pkg::NCHAN; c++) begin : g_chan
        logic [1:0] bus_f;
        assign bus_f = cyc_q[c][ubm_pkg::BUS_POS +: 2];

        // bus steering; 11 falls back to the L-bus
        always_comb begin
            case (bus_f)
                ubm_pkg::BUS_OFF: begin
                    sel_valid[c] = 1'b0;
                    sel_addr[c]  = lbus_address_i;
                    sel_fetch[c] = lbus_fetch_i;
                    sel_write[c] = lbus_write_i;
                    sel_size[c]  = lbus_size_i;
                end
                ubm_pkg::BUS_IBUS: begin
                    sel_valid[c] = ibus_valid_i;
                    sel_addr[c]  = ibus_address_i;
                    sel_fetch[c] = ibus_fetch_i;
                    sel_write[c] = ibus_write_i;
                    sel_size[c]  = ibus_size_i;
                end
                default: begin
                    sel_valid[c] = lbus_valid_i;
                    sel_addr[c]  = lbus_address_i;
                    sel_fetch[c] = lbus_fetch_i;
                    sel_write[c] = lbus_write_i;
                    sel_size[c]  = lbus_size_i;
                end
            endcase
        end

        // same qualifier logic for both channels
        ubm_cycle_qual u_qual (
            .fields_i (cyc_q[c]),
            .fetch_i  (sel_fetch[c]),
            .write_i  (sel_write[c]),
            .size_i   (sel_size[c]),
            .qual_o   (qual[c])
        );

        // masked compare on the selected address
        ubm_addr_cmp u_cmp (
            .addr_i (sel_addr[c]),
            .cmp_i  (addr_q[c]),
            .mask_i (mask_q[c]),
            .eq_o   (addr_eq[c])
        );

        // all checks in the same cycle
        assign match_d[c] = sel_valid[c] & qual[c] & addr_eq[c];
    end

    // break request one cycle after any channel match
    assign brk_d = |match_q;

    // ------------------------------------------------------------
    // register file next state
    // ------------------------------------------------------------
    // single-cycle answer: ack the cycle after the request is seen
    assign take = wb_cyc_i & wb_stb_i & ~ack_q;

    always_comb begin
        addr_d = addr_q;
        mask_d = mask_q;
        cyc_d  = cyc_q;
        seen_d = seen_q;
        rdat_d = rdat_q;
        ack_d  = take;
        if (take && wb_we_i) begin
            case (wb_adr_i)
                ubm_pkg::OFF_A_ADDR: addr_d[0] = merge(addr_q[0], wb_dat_i, wb_sel_i);
                ubm_pkg::OFF_A_MASK: mask_d[0] = merge(mask_q[0], wb_dat_i, wb_sel_i);
                ubm_pkg::OFF_B_ADDR: addr_d[1] = merge(addr_q[1], wb_dat_i, wb_sel_i);
                ubm_pkg::OFF_B_MASK: mask_d[1] = merge(mask_q[1], wb_dat_i, wb_sel_i);
                // upper three bytes of a qualifier are not stored
                ubm_pkg::OFF_A_CYC: begin
                    if (wb_sel_i[0]) begin
                        cyc_d[0] = wb_dat_i[7:0];
                    end
                end
                ubm_pkg::OFF_B_CYC: begin
                    if (wb_sel_i[0]) begin
                        cyc_d[1] = wb_dat_i[7:0];
                    end
                end
                ubm_pkg::OFF_STATUS: begin
                    if (wb_sel_i[0]) begin
                        seen_d = seen_q & ~wb_dat_i[1:0];
                    end
                end
                default: ;
            endcase
        end else if (take) begin
            case (wb_adr_i)
                ubm_pkg::OFF_A_ADDR: rdat_d = addr_q[0];
                ubm_pkg::OFF_A_MASK: rdat_d = mask_q[0];
                ubm_pkg::OFF_B_ADDR: rdat_d = addr_q[1];
                ubm_pkg::OFF_B_MASK: rdat_d = mask_q[1];
                ubm_pkg::OFF_A_CYC:  rdat_d = {24'h000000, cyc_q[0]};
                ubm_pkg::OFF_B_CYC:  rdat_d = {24'h000000, cyc_q[1]};
                ubm_pkg::OFF_STATUS: rdat_d = {30'h0, seen_q};
                default:             rdat_d = 32'h0000_0000;
            endcase
        end
        // a match in the clearing cycle survives the clear
        seen_d = seen_d | match_q;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // everything clears, leaving all channels disabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q  <= {ubm_pkg::ADDR_RST, ubm_pkg::ADDR_RST};
            mask_q  <= {ubm_pkg::MASK_RST, ubm_pkg::MASK_RST};
            cyc_q   <= {ubm_pkg::CYC_RST, ubm_pkg::CYC_RST};
            seen_q  <= ubm_pkg::SEEN_RST;
            ack_q   <= 1'b0;
            rdat_q  <= 32'h0000_0000;
            match_q <= 2'h0;
            brk_q   <= 1'b0;
        end else begin
            addr_q  <= addr_d;
            mask_q  <= mask_d;
            cyc_q   <= cyc_d;
            seen_q  <= seen_d;
            ack_q   <= ack_d;
            rdat_q  <= rdat_d;
            match_q <= match_d;
            brk_q   <= brk_d;
        end
    end

    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = rdat_q;
    assign chan_match_o = match_q;
    assign break_req_o  = brk_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ack_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged next cycle");

    a_resv_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !wb_we_i && (wb_adr_i == ubm_pkg::OFF_A_CYC || wb_adr_i == ubm_pkg::OFF_B_CYC))
        |=> (wb_dat_o[31:8] == 24'h000000))
        else $error("reserved qualifier bits read nonzero");

    // reset sampled at one edge must leave cleared state at the next; the very first
    // edge of the run has no history, so no sampled-past value is used here
    a_reset_clears_all: assert property (@(posedge clk_i)
        rst_i |=> (addr_q == 64'h0 && mask_q == 64'h0 && cyc_q == 16'h0000
                          && chan_match_o == 2'h0))
        else $error("state not cleared by reset");

    a_addr_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && wb_adr_i == ubm_pkg::OFF_A_ADDR && wb_sel_i == 4'hF)
        |=> (addr_q[0] == $past(wb_dat_i)))
        else $error("channel A address write lost");

    a_match_masked_eq: assert property (@(posedge clk_i) disable iff (rst_i)
        chan_match_o[1] |-> $past(((sel_addr[1] ^ addr_q[1]) & ~mask_q[1]) == 32'h0
                                  && sel_valid[1]))
        else $error("channel B matched with unmasked address difference");

    a_bus_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_q[0][7:6] == 2'h0) |=> !chan_match_o[0])
        else $error("channel A matched with bus select off");

    a_ibus_select: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_q[0][7:6] == 2'h2 && !ibus_valid_i) |=> !chan_match_o[0])
        else $error("channel A matched without an I-bus cycle");

    a_dir_write_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (chan_match_o[0] && $past(cyc_q[0][3:2]) == 2'h2) |-> $past(sel_write[0]))
        else $error("write-only channel A matched a read");

    a_size_exact: assert property (@(posedge clk_i) disable iff (rst_i)
        (chan_match_o[0] && $past(cyc_q[0][1:0]) != 2'h0)
        |-> ($past(cyc_q[0][1:0]) == $past(sel_size[0])))
        else $error("channel A matched a wrong operand size");

    a_break_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        (chan_match_o != 2'h0) |=> break_req_o ##1 (break_req_o == $past(chan_match_o != 2'h0)))
        else $error("break request does not follow a match");

    a_acc_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_q[0][5:4] == 2'h0) |=> !chan_match_o[0])
        else $error("channel A matched with access type off");

    // channel B shares the decode, but its own fields must steer it
    a_b_dir_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_q[1][3:2] == 2'h0) |=> !chan_match_o[1])
        else $error("channel B matched with direction off");

    a_b_fetch_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (chan_match_o[1] && $past(cyc_q[1][5:4]) == 2'h1) |-> $past(sel_fetch[1]))
        else $error("fetch-only channel B matched a data access");

    a_b_size_exact: assert property (@(posedge clk_i) disable iff (rst_i)
        (chan_match_o[1] && $past(cyc_q[1][1:0]) != 2'h0)
        |-> ($past(cyc_q[1][1:0]) == $past(sel_size[1])))
        else $error("channel B matched a wrong operand size");

endmodule

// file: sim/ubm_core_bus_model.sv
// core bus model: drives one L-bus or I-bus cycle at a time
// assumes the caller runs just after a rising edge of clk_i
`timescale 1ns/1ps
module ubm_core_bus_model (
    // clock
    input  wire logic        clk_i,
    // L-bus cycle
    output logic             lbus_valid_o,
    output logic      [31:0] lbus_address_o,
    output logic             lbus_fetch_o,
    output logic             lbus_write_o,
    output logic      [1:0]  lbus_size_o,
    // I-bus cycle
    output logic             ibus_valid_o,
    output logic      [31:0] ibus_address_o,
    output logic             ibus_fetch_o,
    output logic             ibus_write_o,
    output logic      [1:0]  ibus_size_o
);
    // quiet at time zero
    initial begin
        {lbus_valid_o, lbus_address_o, lbus_fetch_o, lbus_write_o, lbus_size_o} = '0;
        {ibus_valid_o, ibus_address_o, ibus_fetch_o, ibus_write_o, ibus_size_o} = '0;
    end

    // one cycle on the chosen bus; the other shows inverted values, never a copy
    task automatic drive(input logic ib, input logic [31:0] a, input logic f,
                         input logic w, input logic [1:0] s);
        lbus_valid_o   <= ~ib;
        ibus_valid_o   <= ib;
        lbus_address_o <= ib ? ~a : a;
        ibus_address_o <= ib ? a : ~a;
        {lbus_fetch_o, lbus_write_o, lbus_size_o} <= ib ? ~{f, w, s} : {f, w, s};
        {ibus_fetch_o, ibus_write_o, ibus_size_o} <= ib ? {f, w, s} : ~{f, w, s};
        @(posedge clk_i);
    endtask

    // released buses toggle so a stale value can never pass for a held one
    task automatic idle();
        lbus_valid_o <= 1'b0;
        ibus_valid_o <= 1'b0;
        {lbus_address_o, lbus_fetch_o, lbus_write_o, lbus_size_o} <=
            ~{lbus_address_o, lbus_fetch_o, lbus_write_o, lbus_size_o};
        {ibus_address_o, ibus_fetch_o, ibus_write_o, ibus_size_o} <=
            ~{ibus_address_o, ibus_fetch_o, ibus_write_o, ibus_size_o};
    endtask
endmodule

// file: sim/ubm_break_matcher_bench.sv
// bench for the break matcher: reset and readback cases, table of channel cases, then hand-written cases
// assumes the core bus model sits on both core buses
`timescale 1ns/1ps
module ubm_break_matcher_bench;
    typedef struct packed {
        logic [7:0]  cyc;
        logic [31:0] mask;
        logic [31:0] addr;
        logic        ib;
        logic        f;
        logic        w;
        logic [1:0]  s;
        logic        exp;
    } ubm_row_type;
    localparam logic [31:0] C = 32'h1234_5678;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, lv, lf, lw, iv, ifc, iw, break_req_o;
    logic [31:0] la, ia;
    logic [1:0]  ls, is, chan_match_o;
    int          err_count = 0;
    int          comparisons = 0;
    ubm_row_type rows [22];

    always #2 clk_i = ~clk_i;

    ubm_break_matcher dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .lbus_valid_i(lv), .lbus_address_i(la), .lbus_fetch_i(lf), .lbus_write_i(lw),
        .lbus_size_i(ls), .ibus_valid_i(iv), .ibus_address_i(ia), .ibus_fetch_i(ifc),
        .ibus_write_i(iw), .ibus_size_i(is), .chan_match_o(chan_match_o),
        .break_req_o(break_req_o));
    ubm_core_bus_model bus_u (.clk_i(clk_i), .lbus_valid_o(lv), .lbus_address_o(la),
        .lbus_fetch_o(lf), .lbus_write_o(lw), .lbus_size_o(ls), .ibus_valid_o(iv),
        .ibus_address_o(ia), .ibus_fetch_o(ifc), .ibus_write_o(iw), .ibus_size_o(is));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // classic cycle: held until ack is sampled high at a rising edge, released there
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            err_count++;
            end_sim();
        end
        // read data taken at the ack edge, then cyc and stb drop for a cycle
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check("read data", q, exp);
    endtask
    // one core cycle, then match one cycle later and break request after that
    task automatic cyc_chk(input ubm_row_type r, input logic [1:0] m);
        bus_u.drive(r.ib, r.addr, r.f, r.w, r.s);
        bus_u.idle();
        @(negedge clk_i);
        check("chan_match", 32'(chan_match_o), 32'(m));
        @(negedge clk_i);
        check("break_req", 32'(break_req_o), 32'(|m));
        @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{'{8'h7C, 0, C, 0, 0, 0, 2, 1}, '{8'h7C, 0, C, 1, 0, 0, 2, 0},
                 '{8'hBC, 0, C, 1, 0, 0, 2, 1}, '{8'hBC, 0, C, 0, 0, 0, 2, 0},
                 '{8'hFC, 0, C, 0, 0, 0, 2, 1}, '{8'h3C, 0, C, 0, 0, 0, 2, 0},
                 '{8'h5C, 0, C, 0, 1, 0, 2, 1}, '{8'h5C, 0, C, 0, 0, 0, 2, 0},
                 '{8'h6C, 0, C, 0, 0, 0, 2, 1}, '{8'h4C, 0, C, 0, 1, 0, 2, 0},
                 '{8'h74, 0, C, 0, 0, 0, 2, 1}, '{8'h74, 0, C, 0, 0, 1, 2, 0},
                 '{8'h78, 0, C, 0, 0, 1, 2, 1}, '{8'h70, 0, C, 0, 0, 1, 2, 0},
                 '{8'h7D, 0, C, 0, 0, 0, 1, 1}, '{8'h7E, 0, C, 0, 0, 0, 1, 0},
                 '{8'h7F, 0, C, 0, 0, 0, 3, 1},
                 '{8'h7C, 32'hFF, C ^ 32'h81, 0, 0, 0, 2, 1},
                 '{8'h7C, 32'h7F, C ^ 32'h81, 0, 0, 0, 2, 0},
                 '{8'h7C, 32'h8000_0000, C ^ 32'h8000_0000, 0, 0, 0, 2, 1},
                 '{8'hB5, 0, C, 1, 0, 0, 1, 1},
                 '{8'h7C, 0, C ^ 32'h1, 0, 0, 0, 2, 0}};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // everything reads zero after reset, the unmapped word too
        for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
        cyc_chk(rows[0], 2'b00);
        // readback; upper qualifier bits written high on purpose must drop
        wb(1'b1, ubm_pkg::OFF_A_MASK, 32'hA5A5_0FF0);
        rd(ubm_pkg::OFF_A_MASK, 32'hA5A5_0FF0);
        wb(1'b1, ubm_pkg::OFF_A_CYC, 32'h0000_FF7C);
        rd(ubm_pkg::OFF_A_CYC, 32'h0000_007C);
        wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0);
        // table: every field code on each channel, the other channel left off
        for (int ch = 0; ch < 2; ch++) begin
            wb(1'b1, ch ? ubm_pkg::OFF_B_ADDR : ubm_pkg::OFF_A_ADDR, C);
            rd(ch ? ubm_pkg::OFF_B_ADDR : ubm_pkg::OFF_A_ADDR, C);
            for (int i = 0; i < 22; i++) begin
                // upper qualifier bits written as zero
                wb(1'b1, ch ? ubm_pkg::OFF_B_CYC : ubm_pkg::OFF_A_CYC, {24'h0, rows[i].cyc});
                wb(1'b1, ch ? ubm_pkg::OFF_B_MASK : ubm_pkg::OFF_A_MASK, rows[i].mask);
                cyc_chk(rows[i], 2'(rows[i].exp) << ch);
            end
            wb(1'b1, ubm_pkg::OFF_A_CYC, 32'h0);
        end
        // sticky seen bits, cleared by writing ones
        rd(ubm_pkg::OFF_STATUS, 32'h3);
        wb(1'b1, ubm_pkg::OFF_STATUS, 32'h1);
        rd(ubm_pkg::OFF_STATUS, 32'h2);
        wb(1'b1, ubm_pkg::OFF_STATUS, 32'h2);
        rd(ubm_pkg::OFF_STATUS, 32'h0);
        // back-to-back matching cycles on channel B
        bus_u.drive(1'b0, C, 1'b0, 1'b0, 2'h2);
        bus_u.drive(1'b0, C, 1'b0, 1'b0, 2'h2);
        bus_u.idle();
        @(negedge clk_i);
        check("b2b match", 32'(chan_match_o), 32'h2);
        check("b2b break", 32'(break_req_o), 32'h1);
        @(negedge clk_i);
        check("b2b break", 32'(break_req_o), 32'h1);
        @(negedge clk_i);
        check("b2b break", 32'(break_req_o), 32'h0);
        // reset in mid-run wipes the programmed channel
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ubm_pkg::OFF_B_ADDR, 32'h0);
        rd(ubm_pkg::OFF_B_CYC, 32'h0);
        cyc_chk(rows[0], 2'b00);
        end_sim();
    end
endmodule
